// [logic/wdsup_pkg.sv]
// constants shared by the windowed supervisor design
// assumes one 50 MHz clock; the supervisor tick is a prescaled enable
package wdsup_pkg;
    // register indices on the plain register port
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_RELOAD = 4'h1;
    localparam logic [3:0] ADDR_FEED = 4'h2;
    localparam logic [3:0] ADDR_COUNT = 4'h3;
    localparam logic [3:0] ADDR_WARN = 4'h4;
    localparam logic [3:0] ADDR_WINDOW = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    // control field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_RST_BIT = 1;
    localparam int CTRL_PROT_BIT = 2;
    localparam int CTRL_SLEEP_BIT = 3;
    localparam int CTRL_DBGFRZ_BIT = 4;
    localparam int CTRL_WIN_BIT = 5;
    // status field positions
    localparam int STAT_TOF_BIT = 0;
    localparam int STAT_WARN_BIT = 1;
    localparam int STAT_LOCK_BIT = 2;
    // feed keys, written back to back
    localparam logic [7:0] FEED_KEY_A = 8'hAA;
    localparam logic [7:0] FEED_KEY_B = 8'h55;
    // counter widths, limits and reset values
    localparam int CNT_W = 24;
    localparam logic [23:0] CNT_MIN = 24'h0000FF;
    localparam logic [23:0] RELOAD_RST = 24'h0000FF;
    localparam logic [23:0] WINDOW_RST = 24'hFFFFFF;
    localparam logic [9:0] WARN_RST = 10'h000;
    localparam logic [5:0] CTRL_RST = 6'h00;
    // supervisor tick: nominal oscillator rate, and divide-by-4 prescale
    localparam int CLK_HZ = 50000000;
    localparam int TICK_HZ = 500000;
    localparam int TICK_DIV = CLK_HZ / TICK_HZ;
    localparam int PRESCALE = 4;
endpackage

// [logic/wdsup_tick.sv]
// tick divider: makes the supervisor clock enable and the prescaled count enable
// assumes clk_i is the system clock and rst_n_i is already synchronised
`timescale 1ns/100ps
module wdsup_tick (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    output logic cnt_en_o
);
    logic [7:0] div_r;
    logic [1:0] pre_r;
    logic tick;

    // supervisor clock enable; the oscillator is modelled as a divider
    assign tick = (div_r == 8'(wdsup_pkg::TICK_DIV - 1));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_r <= 8'h00;
        end else if (tick) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // fixed divide-by-4 prescaler; held while frozen
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_r <= 2'h0;
            cnt_en_o <= 1'b0;
        end else begin
            cnt_en_o <= 1'b0;
            if (tick && run_i) begin
                pre_r <= pre_r + 2'h1;
                cnt_en_o <= (pre_r == 2'(wdsup_pkg::PRESCALE - 1));
            end
        end
    end
endmodule

// [logic/wdsup_top.sv]
// windowed watchdog supervisor: counter, feed check, window, warning, lock
// assumes software on the plain register port; chip reset is arst_n_i
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps
module wdsup_top (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic sleep_i,
    input wire logic dbg_halt_i,
    input wire logic wd_reset_seen_i,
    output logic [31:0] rdata_o,
    output logic chip_rst_o,
    output logic warn_irq_o
);
    logic rst_s1_r;
    logic rst_n_r;
    logic [5:0] ctrl_r;
    logic [23:0] reload_r;
    logic [23:0] count_r;
    logic [9:0] warn_r;
    logic [23:0] window_r;
    logic tof_r;
    logic warn_flag_r;
    logic key_a_r;
    logic started_r;
    logic cnt_en;
    logic run;
    logic locked;
    logic feed_wr;
    logic feed_ok;
    logic feed_bad;
    logic early;
    logic timeout;
    logic below_warn;
    logic reload_wr_ok;
    logic event_fire;
    logic [23:0] reload_nxt;

    // reset release through two flops; the chip reset itself is async
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    assign locked = ctrl_r[wdsup_pkg::CTRL_EN_BIT];
    // counting stops in sleep unless enabled for it, and under debug halt when the freeze bit is set
    assign run = started_r && !(sleep_i && !ctrl_r[wdsup_pkg::CTRL_SLEEP_BIT])
        && !(dbg_halt_i && ctrl_r[wdsup_pkg::CTRL_DBGFRZ_BIT]);

    wdsup_tick u_tick (
        .clk_i(clk_i),
        .rst_n_i(rst_n_r),
        .run_i(run),
        .cnt_en_o(cnt_en)
    );

    // feed decode: second key must directly follow the first
    assign feed_wr = wr_i && (addr_i == wdsup_pkg::ADDR_FEED);
    assign feed_ok = feed_wr && key_a_r && (wdata_i[7:0] == wdsup_pkg::FEED_KEY_B);
    assign feed_bad = locked && ((key_a_r && !feed_ok)
        || (feed_wr && !key_a_r && (wdata_i[7:0] != wdsup_pkg::FEED_KEY_A)));
    // an in-sequence feed above the window limit is too early
    assign early = ctrl_r[wdsup_pkg::CTRL_WIN_BIT] && (count_r > window_r);
    assign timeout = started_r && cnt_en && (count_r == 24'h000000);
    assign below_warn = (count_r <= {14'h0000, warn_r});
    // protection opens the reload only once the warning point is passed
    assign reload_wr_ok = !ctrl_r[wdsup_pkg::CTRL_PROT_BIT] || below_warn;
    assign event_fire = timeout || feed_bad || (feed_ok && early && locked);

    // reload below the minimum is raised to it, keeping the 255-count floor
    always_comb begin
        reload_nxt = wdata_i[23:0];
        if (wdata_i[23:0] < wdsup_pkg::CNT_MIN) begin
            reload_nxt = wdsup_pkg::CNT_MIN;
        end
    end

    // feed sequencer state
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            key_a_r <= 1'b0;
        end else begin
            key_a_r <= feed_wr && !key_a_r && (wdata_i[7:0] == wdsup_pkg::FEED_KEY_A);
        end
    end

    // control: writable until the enable bit is set; then all bits, enable included, are frozen
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctrl_r <= wdsup_pkg::CTRL_RST;
        end else if (wr_i && addr_i == wdsup_pkg::ADDR_CTRL && !locked) begin
            ctrl_r <= wdata_i[5:0];
        end else if (wr_i && addr_i == wdsup_pkg::ADDR_CTRL) begin
            ctrl_r <= ctrl_r;
        end
    end

    // reload, warning and window values; warning and window never change once locked
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            reload_r <= wdsup_pkg::RELOAD_RST;
            warn_r <= wdsup_pkg::WARN_RST;
            window_r <= wdsup_pkg::WINDOW_RST;
        end else if (wr_i) begin
            if (addr_i == wdsup_pkg::ADDR_RELOAD && reload_wr_ok) begin
                reload_r <= reload_nxt;
            end
            if (addr_i == wdsup_pkg::ADDR_WARN && !locked) begin
                warn_r <= wdata_i[9:0];
            end
            if (addr_i == wdsup_pkg::ADDR_WINDOW && !locked) begin
                window_r <= wdata_i[23:0];
            end
        end
    end

    // down counter: first valid feed once enabled starts it, later feeds reload it unless too early
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            count_r <= wdsup_pkg::RELOAD_RST;
            started_r <= 1'b0;
        end else if (feed_ok && !event_fire) begin
            count_r <= reload_r;
            started_r <= locked;
        end else if (cnt_en && count_r != 24'h000000) begin
            count_r <= count_r - 24'h000001;
        end
    end

    // time-out flag: sticky; set wins over a software clear of the same cycle
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tof_r <= 1'b0;
        end else if (event_fire) begin
            tof_r <= 1'b1;
        end else if (wr_i && addr_i == wdsup_pkg::ADDR_STATUS
                     && wdata_i[wdsup_pkg::STAT_TOF_BIT]) begin
            tof_r <= 1'b0;
        end
    end

    // warning flag: set as count meets the point; write-one clears, set wins
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            warn_flag_r <= 1'b0;
        end else if (started_r && count_r == {14'h0000, warn_r}) begin
            warn_flag_r <= 1'b1;
        end else if (wr_i && addr_i == wdsup_pkg::ADDR_STATUS
                     && wdata_i[wdsup_pkg::STAT_WARN_BIT]) begin
            warn_flag_r <= 1'b0;
        end
    end

    // outputs: chip reset request only when reset mode selected
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            chip_rst_o <= 1'b0;
            warn_irq_o <= 1'b0;
        end else begin
            chip_rst_o <= event_fire && ctrl_r[wdsup_pkg::CTRL_RST_BIT] && locked;
            warn_irq_o <= warn_flag_r;
        end
    end

    // read port; the cause strap lives outside so it survives our own reset
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdata_o <= 32'h00000000;
        end else if (rd_i) begin
            case (addr_i)
                wdsup_pkg::ADDR_CTRL: rdata_o <= {26'h0000000, ctrl_r};
                wdsup_pkg::ADDR_RELOAD: rdata_o <= {8'h00, reload_r};
                wdsup_pkg::ADDR_COUNT: rdata_o <= {8'h00, count_r};
                wdsup_pkg::ADDR_WARN: rdata_o <= {22'h000000, warn_r};
                wdsup_pkg::ADDR_WINDOW: rdata_o <= {8'h00, window_r};
                wdsup_pkg::ADDR_STATUS: rdata_o <= {28'h0000000, wd_reset_seen_i, locked,
                                                    warn_flag_r, tof_r};
                default: rdata_o <= 32'h00000000;
            endcase
        end else begin
            rdata_o <= 32'h00000000;
        end
    end
endmodule

// [tb/wdsup_chk.sv]
// port checker for the windowed supervisor top
// assumes only the top ports; ctrl writes are tracked here to know the armed mode
`timescale 1ns/100ps
module wdsup_chk (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic wd_reset_seen_i,
    input wire logic [31:0] rdata_o,
    input wire logic chip_rst_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    logic [1:0] mode_r;
    // enable and reset mode; frozen once enabled, as the design locks them
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_r <= 2'h0;
        end else if (wr_i && addr_i == wdsup_pkg::ADDR_CTRL && !mode_r[0]) begin
            mode_r <= wdata_i[1:0];
        end
    end
    property p_pulse; chip_rst_o |=> !chip_rst_o; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse too long");
    property p_quiet; !(&mode_r) |-> !chip_rst_o; endproperty
    a_quiet: assert property (p_quiet) else $error("reset while not armed");
    property p_bad;
        wr_i && addr_i == wdsup_pkg::ADDR_FEED && wdata_i[7:0] == wdsup_pkg::FEED_KEY_A
        && (&mode_r) ##1 wr_i && addr_i == wdsup_pkg::ADDR_FEED
        && wdata_i[7:0] != wdsup_pkg::FEED_KEY_B |-> ##[0:3] chip_rst_o;
    endproperty
    a_bad: assert property (p_bad) else $error("bad feed gave no reset");
    property p_lock; rd_i && addr_i == wdsup_pkg::ADDR_CTRL && mode_r[0] |=> rdata_o[0]; endproperty
    a_lock: assert property (p_lock) else $error("enable bit lost");
    property p_min; rd_i && addr_i == wdsup_pkg::ADDR_RELOAD |=> rdata_o[23:0] >= 24'h0000FF; endproperty
    a_min: assert property (p_min) else $error("reload below minimum");
    property p_cnt; rd_i && addr_i == wdsup_pkg::ADDR_COUNT |=> rdata_o[31:24] == 8'h00; endproperty
    a_cnt: assert property (p_cnt) else $error("count wider than 24 bits");
    property p_warn; rd_i && addr_i == wdsup_pkg::ADDR_WARN |=> rdata_o[31:10] == 22'h0; endproperty
    a_warn: assert property (p_warn) else $error("warn point too wide");
    property p_seen;
        rd_i && addr_i == wdsup_pkg::ADDR_STATUS |=> rdata_o[3] == $past(wd_reset_seen_i);
    endproperty
    a_seen: assert property (p_seen) else $error("reset cause flag wrong");
endmodule
bind wdsup_top wdsup_chk i_wdsup_chk (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .wd_reset_seen_i, .rdata_o, .chip_rst_o);

// [tb/tb_wdsup_top.sv]
// self-checking bench for the windowed supervisor
// assumes the plain register port; full time-outs are too long to run here
`timescale 1ns/100ps
module tb_wdsup_top;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic sleep_i = 1'b0;
    logic dbg_halt_i = 1'b0;
    logic wd_reset_seen_i = 1'b0;
    logic [31:0] rdata_o;
    logic chip_rst_o;
    logic warn_irq_o;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    wdsup_top i_wdsup_top (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .sleep_i,
        .dbg_halt_i, .wd_reset_seen_i, .rdata_o, .chip_rst_o, .warn_irq_o);
    // 50 MHz clock
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // hang guard: the tests need under four thousand cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            errors = errors + 1;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // strobes are lowered at the edge, the next access starts just after it
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(what, rdata_o, exp);
    endtask
    task automatic feed();
        wr(wdsup_pkg::ADDR_FEED, 32'h000000AA);
        wr(wdsup_pkg::ADDR_FEED, 32'h00000055);
    endtask
    task automatic do_reset(input logic seen);
        arst_n_i <= 1'b0;
        wd_reset_seen_i <= seen;
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    task automatic expect_rst(input string what);
        logic seen;
        seen = 1'b0;
        repeat (4) begin
            if (chip_rst_o === 1'b1) seen = 1'b1;
            @(posedge clk_i);
            #1;
        end
        chk(what, {31'h0, seen}, 32'h1);
    endtask
    initial begin
        do_reset(1'b0);
        rd(wdsup_pkg::ADDR_CTRL, 32'h0, "ctrl");
        rd(wdsup_pkg::ADDR_WINDOW, 32'h00FFFFFF, "window");
        rd(wdsup_pkg::ADDR_WARN, 32'h0, "warn");
        rd(wdsup_pkg::ADDR_STATUS, 32'h0, "status");
        rd(4'hF, 32'h0, "unmapped");
        wr(wdsup_pkg::ADDR_RELOAD, 32'h00000010);
        rd(wdsup_pkg::ADDR_RELOAD, 32'h000000FF, "reload clamp");
        wr(wdsup_pkg::ADDR_RELOAD, 32'h00001234);
        wr(wdsup_pkg::ADDR_CTRL, 32'h00000003);
        wr(wdsup_pkg::ADDR_CTRL, 32'h0);
        wr(wdsup_pkg::ADDR_WINDOW, 32'h00000100);
        rd(wdsup_pkg::ADDR_CTRL, 32'h3, "ctrl locked");
        rd(wdsup_pkg::ADDR_WINDOW, 32'h00FFFFFF, "window locked");
        rd(wdsup_pkg::ADDR_STATUS, 32'h4, "lock flag");
        feed();
        rd(wdsup_pkg::ADDR_COUNT, 32'h00001234, "count loaded");
        wr(wdsup_pkg::ADDR_FEED, 32'h000000AA);
        wr(wdsup_pkg::ADDR_FEED, 32'h00000012);
        expect_rst("bad feed");
        $display("test lock and feed done");
        // the supervisor's own reset pulse comes back as a chip reset
        do_reset(1'b1);
        rd(wdsup_pkg::ADDR_STATUS, 32'h8, "wd cause");
        wr(wdsup_pkg::ADDR_RELOAD, 32'h00001000);
        wr(wdsup_pkg::ADDR_WINDOW, 32'h00000100);
        wr(wdsup_pkg::ADDR_CTRL, 32'h00000023);
        feed();
        feed();
        expect_rst("early feed");
        $display("test window done");
        do_reset(1'b0);
        wr(wdsup_pkg::ADDR_RELOAD, 32'h00000100);
        wr(wdsup_pkg::ADDR_WARN, 32'h000000FF);
        wr(wdsup_pkg::ADDR_CTRL, 32'h00000005);
        feed();
        wr(wdsup_pkg::ADDR_RELOAD, 32'h00000300);
        rd(wdsup_pkg::ADDR_RELOAD, 32'h00000100, "reload guarded");
        repeat (1000) @(posedge clk_i);
        #1;
        chk("warn irq", {31'h0, warn_irq_o}, 32'h1);
        wr(wdsup_pkg::ADDR_RELOAD, 32'h00000300);
        rd(wdsup_pkg::ADDR_RELOAD, 32'h00000300, "reload open");
        $display("test warning done");
        // halt freeze, then sleep without the run-in-sleep bit: count must hold
        do_reset(1'b0);
        wr(wdsup_pkg::ADDR_RELOAD, 32'h00000100);
        wr(wdsup_pkg::ADDR_CTRL, 32'h00000011);
        dbg_halt_i <= 1'b1;
        feed();
        repeat (1000) @(posedge clk_i);
        #1;
        rd(wdsup_pkg::ADDR_COUNT, 32'h00000100, "count frozen");
        sleep_i <= 1'b1;
        dbg_halt_i <= 1'b0;
        repeat (1000) @(posedge clk_i);
        #1;
        rd(wdsup_pkg::ADDR_COUNT, 32'h00000100, "count sleeping");
        sleep_i <= 1'b0;
        $display("test freeze done");
        give_verdict();
    end
endmodule
